/* File: verilog/dss_pkg.sv */
/*
 * Constants, types and the velocity table for the disk seek sequencer.
 * Assumes a single 200 MHz clock; every time is turned into cycles here.
 */
// Overview of operation
// - Same destination: stay on cylinder, no motion.
// - Tag latches 10-bit destination into cylinder register.
// - New destination: clear on-cylinder, pulse seek interrupt.
// - Control pulses step nibble mux, then head.
// - Destination above 710 is a seek error.
// - Compare addresses: tracks to go, direction.
// - Drive direction line, preset velocity latch.
// - Start only without fault, demod valid, speed good.
// - Load 60 ms timer; expiry is seek error.
// - Set slope select for destination phase.
// - Raise track-follow-n and coarse, then accelerate.
// - One track: release clamp, 16 increments, hold.
// - One track: fine enable low enters fine loop.
// - Multi track: step code every 43 us.
// - Early in seek load counter, crossings decrement.
// - Stop accelerating at table entry, then follow.
// - Decel: update per crossing, clamp pulse, integrate below 40.
// - Fine enable low: coarse, settle low; 0.8 ms later follow.
// - Settle 2.1 ms; loss allows 11 ms, restart.
// - Three crossings while settling is seek error.
// - Success: flasher low, on-cylinder and seek end.
// - Failure: seek error, seek end, status code.
package dss_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ        = 200;   // Clock rate
	localparam int unsigned T_TIMEOUT_US   = 60000; // Seek timeout, 60 ms
	localparam int unsigned T_STEP_NS      = 43000; // Accel step, 43 us
	localparam int unsigned T_CAPTURE_US   = 800;   // Capture delay, 0.8 ms
	localparam int unsigned T_SETTLE_US    = 2100;  // Settle check, 2.1 ms
	localparam int unsigned T_REGAIN_US    = 11000; // Regain window, 11 ms
	localparam int unsigned TIMEOUT_CYC    = T_TIMEOUT_US * CLK_MHZ;
	localparam int unsigned STEP_CYC       = T_STEP_NS * CLK_MHZ / 1000;
	localparam int unsigned CAPTURE_CYC    = T_CAPTURE_US * CLK_MHZ;
	localparam int unsigned SETTLE_CYC     = T_SETTLE_US * CLK_MHZ;
	localparam int unsigned REGAIN_CYC     = T_REGAIN_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Seek limits and profile figures
	// ----------------------------------------------------------------
	localparam logic [9:0] MAX_TRACK   = 10'h2c6; // Highest legal track 710
	localparam logic [9:0] ONE_TRACK   = 10'h001;
	localparam logic [9:0] INTEG_T     = 10'h028; // Integrate below 40
	localparam logic [9:0] LE8_T       = 10'h008;
	localparam logic [4:0] ONE_INCS    = 5'h10;   // One-track increments
	localparam logic [1:0] OVERSHOOT_N = 2'h3;    // Crossings while settling
	localparam logic [9:0] VT_FULL     = 10'h040; // Coast from this distance
	localparam int         DAC_B6      = 6;
	localparam int         DAC_B7      = 7;

	// ----------------------------------------------------------------
	// Status codes for the fault display
	// ----------------------------------------------------------------
	localparam logic [3:0] FC_NONE    = 4'h0;
	localparam logic [3:0] FC_ILLEGAL = 4'h1;
	localparam logic [3:0] FC_COND    = 4'h2;
	localparam logic [3:0] FC_TIMEOUT = 4'h3;
	localparam logic [3:0] FC_REGAIN  = 4'h4;
	localparam logic [3:0] FC_OVER    = 4'h5;
	localparam logic [3:0] FC_FINAL   = 4'h6;

	// ----------------------------------------------------------------
	// Register map (byte addresses, low bits of haddr)
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL   = 8'h00; // en, step pulse, rewind
	localparam logic [7:0] A_STATUS = 8'h04; // flags, code, state
	localparam logic [7:0] A_ADDR   = 8'h08; // destination, present
	localparam logic [7:0] A_HEAD   = 8'h0c; // head address
	localparam logic [7:0] A_MUX    = 8'h10; // multiplexed path
	localparam int         C_EN     = 0;
	localparam int         C_STEP   = 1;
	localparam int         C_REWIND = 2;
	localparam int         PRES_LSB = 16;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic fault;        // Drive fault present
		logic demod_n;      // Servo demodulator valid, active low
		logic speed_ok;     // Spindle speed good
		logic fine_n;       // Fine enable, active low
		logic oc_sense;     // On-cylinder sense
		logic cyl_pulse;    // Cylinder crossing pulse
		logic guard;        // Inner or outer guard band pulse
	} dss_sense_t;

	typedef struct packed {
		logic       forward_n;      // Low for inward seeks
		logic       vel_latch;      // Velocity measurement preset
		logic       slope;          // Position slope select
		logic       track_follow_n; // Track follow, active low
		logic       coarse;         // Coarse loop select
		logic       settle_in_n;    // Settle in, active low
		logic       integ_clamp;    // Integrator clamp
		logic       t_eq1;          // One track to go
		logic       t_le8;          // Eight or fewer to go
		logic       flasher;        // Enable flasher
		logic [7:0] dac;            // Velocity converter code
	} dss_servo_t;

	typedef enum logic [8:0] {
		ST_IDLE    = 9'h001,
		ST_CHECK   = 9'h002,
		ST_ONE     = 9'h004,
		ST_ACCEL   = 9'h008,
		ST_DECEL   = 9'h010,
		ST_CAPTURE = 9'h020,
		ST_WAIT_OC = 9'h040,
		ST_SETTLE  = 9'h080,
		ST_REGAIN  = 9'h100
	} dss_state_t;

	// Velocity table: demanded code for a distance still to go
	function automatic logic [7:0] vel_table(input logic [9:0] t);
		logic [7:0] v;
		v = (t >= VT_FULL) ? 8'hff : {t[5:0], 2'h3};
		return v;
	endfunction

endpackage

/* File: verilog/dss_sync.sv */
/*
 * Two-stage synchroniser for a vector of pin inputs.
 * Assumes the inputs are asynchronous levels; the first stage is read
 * only by the second.
 */
`timescale 1ns/1ps
`default_nettype none
module dss_sync #(
	parameter int W = 18
) (
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;  // First stage
		logic [W-1:0] sync;  // Second stage
	} dss_sync_st_t;

	dss_sync_st_t r;
	dss_sync_st_t next_r;

	// Per bit shift through both stages
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			next_r.meta[i] = d_i[i];
			next_r.sync[i] = r.meta[i];
		end
	end

	// Register the stages
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_o = r.sync;

endmodule
`default_nettype wire

/* File: verilog/dss_seq.sv */
/*
 * Disk seek sequencer: latches the destination cylinder on the select
 * tag, checks it, runs the coarse velocity profile, the switch to the
 * fine loop and the settle check, and reports on-cylinder or error.
 * Assumes the host holds the bus steady around the tag, servo pins are
 * asynchronous, and software reaches the registers over AHB-Lite.
 */
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dss_seq #(
	parameter int unsigned TIMEOUT_CYC = dss_pkg::TIMEOUT_CYC,
	parameter int unsigned STEP_CYC    = dss_pkg::STEP_CYC,
	parameter int unsigned CAPTURE_CYC = dss_pkg::CAPTURE_CYC,
	parameter int unsigned SETTLE_CYC  = dss_pkg::SETTLE_CYC,
	parameter int unsigned REGAIN_CYC  = dss_pkg::REGAIN_CYC
) (
	input  wire logic               clock_i,
	input  wire logic               rst_n_i,
	// Host interface
	input  wire logic               cyl_tag_i,
	input  wire logic [9:0]         cyl_bus_i,
	// Servo
	input  wire dss_pkg::dss_sense_t sense_i,
	output dss_pkg::dss_servo_t     servo_o,
	output logic                    seek_irq_o,
	output logic                    track_reached_flag_o,
	output logic                    positioning_fault_flag_o,
	output logic                    seek_end_o,
	output logic [3:0]              fault_code_o,
	output logic [4:0]              addr_path_o,
	// AHB-Lite slave
	input  wire logic               hsel_i,
	input  wire logic [31:0]        haddr_i,
	input  wire logic [1:0]         htrans_i,
	input  wire logic               hwrite_i,
	input  wire logic [2:0]         hsize_i,
	input  wire logic [31:0]        hwdata_i,
	input  wire logic               hready_i,
	output logic [31:0]             hrdata_o,
	output logic                    hreadyout_o,
	output logic                    hresp_o
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_q;   // Release shift
	logic       rst_n;   // Synchronous copy

	// Assert at once, release after two edges
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int SW = $bits(dss_pkg::dss_sense_t) + 11;

	logic [SW-1:0]        sync_q;  // Synchronised pins
	dss_pkg::dss_sense_t  s;       // Synchronised sense
	logic                 s_tag;   // Synchronised tag
	logic [9:0]           s_bus;   // Synchronised bus

	dss_sync #(.W(SW)) u_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n),
		.d_i     ({sense_i, cyl_tag_i, cyl_bus_i}),
		.q_o     (sync_q)
	);
	assign {s, s_tag, s_bus} = sync_q;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		dss_pkg::dss_state_t st;       // Sequencer state
		dss_pkg::dss_servo_t srv;      // Servo lines
		logic [9:0]          cyl;      // Cylinder address register
		logic [9:0]          present;  // Present cylinder
		logic [4:0]          head;     // Head address
		logic [1:0]          midx;     // Mux step
		logic [4:0]          path;     // Mux output
		logic                en;       // Seeks accepted
		logic                tag_d;    // Tag, last cycle
		logic                cp_d;     // Crossing, last cycle
		logic [9:0]          ttg;      // Tracks to go counter
		logic                loaded;   // Counter loaded
		logic [4:0]          inc;      // One-track increments
		logic [31:0]         tmr;      // Phase timer
		logic [31:0]         tout;     // Seek timeout timer
		logic [31:0]         step;     // Accel step divider
		logic [1:0]          pcnt;     // Crossings while settling
		logic                guard;    // Guard pulse while settling
		logic                on_cyl;   // Track reached
		logic                err;      // Positioning fault
		logic                send;     // Seek end
		logic                irq;      // Seek interrupt one-shot
		logic [3:0]          code;     // Status code
		logic                ap_wr;    // Write in data phase
		logic [7:0]          ap_addr;  // Data phase address
		logic [31:0]         rdata;    // Read data
		logic                ready;    // Ready out
	} dss_st_t;

	dss_st_t r;
	dss_st_t next_r;

	logic       tag_rise;  // Tag leading edge
	logic       cp;        // Crossing edge
	logic       tick;      // Accel step enable
	logic       moving;    // Seek in progress
	logic       fail;      // Seek fails this cycle
	logic       done;      // Seek succeeds this cycle
	logic [3:0] fcode;     // Failure code
	logic [9:0] ttg_dec;   // Counter less one
	logic       ap_ok;     // Valid address phase
	logic [31:0] rd;       // Addressed register

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r   = r;
		next_r.irq = 1'b0;
		next_r.tag_d = s_tag;
		next_r.cp_d  = s.cyl_pulse;
		tag_rise = s_tag & ~r.tag_d;
		cp       = s.cyl_pulse & ~r.cp_d;
		tick     = (r.step == 32'h0);
		moving   = (r.st != dss_pkg::ST_IDLE) && (r.st != dss_pkg::ST_CHECK);
		fail     = 1'b0;
		done     = 1'b0;
		fcode    = dss_pkg::FC_NONE;
		ttg_dec  = r.ttg - 10'h001;
		// Free timers
		next_r.step = tick ? 32'(STEP_CYC - 1) : r.step - 32'h1;
		if (r.tmr != 32'h0) begin
			next_r.tmr = r.tmr - 32'h1;
		end
		if (r.tout != 32'h0) begin
			next_r.tout = r.tout - 32'h1;
		end
		// Counter follows every crossing of a seek once loaded, down to zero
		if (moving && r.loaded && cp && r.ttg != 10'h0) begin
			next_r.ttg = ttg_dec;
		end
		case (r.st)
			// Wait for a select tag
			dss_pkg::ST_IDLE: begin
				if (tag_rise && r.en) begin
					next_r.cyl = s_bus;
					if (s_bus != r.cyl) begin
						next_r.on_cyl = 1'b0;
						next_r.irq    = 1'b1;
						next_r.err    = 1'b0;
						next_r.send   = 1'b0;
						next_r.code   = dss_pkg::FC_NONE;      // Old code must not outlive its seek
						next_r.st     = dss_pkg::ST_CHECK;
					end
					// Equal address leaves everything as it is
				end
			end
			// Check address and conditions, preset lines
			dss_pkg::ST_CHECK: begin
				next_r.srv.forward_n = ~(r.cyl > r.present);
				next_r.ttg = (r.cyl > r.present) ? r.cyl - r.present
				                                 : r.present - r.cyl;
				next_r.srv.dac = 8'h00;
				next_r.srv.vel_latch = r.srv.dac[dss_pkg::DAC_B6] ^
				                       r.srv.dac[dss_pkg::DAC_B7] ^
				                       ~(r.cyl > r.present);
				next_r.loaded = 1'b0;
				next_r.inc    = 5'h00;
				if (r.cyl > dss_pkg::MAX_TRACK) begin
					fail  = 1'b1;
					fcode = dss_pkg::FC_ILLEGAL;
				end else if (s.fault || s.demod_n || !s.speed_ok) begin
					fail  = 1'b1;
					fcode = dss_pkg::FC_COND;
				end else if (r.cyl == r.present) begin
					done = 1'b1;
				end else begin
					next_r.tout = 32'(TIMEOUT_CYC);
					next_r.step = 32'(STEP_CYC - 1);
					next_r.srv.slope = r.cyl[0];
					next_r.srv.track_follow_n = 1'b1;
					next_r.srv.coarse      = 1'b1;
					next_r.srv.settle_in_n = 1'b1;
					next_r.srv.flasher     = 1'b1;
					if (next_r.ttg == dss_pkg::ONE_TRACK) begin
						next_r.srv.integ_clamp = 1'b0;
						next_r.srv.t_eq1 = 1'b1;
						next_r.srv.t_le8 = 1'b1;
						next_r.st = dss_pkg::ST_ONE;
					end else begin
						next_r.srv.integ_clamp = 1'b1;
						next_r.st = dss_pkg::ST_ACCEL;
					end
				end
			end
			// One track: ramp sixteen steps then hold
			dss_pkg::ST_ONE: begin
				if (tick && r.inc != dss_pkg::ONE_INCS) begin
					next_r.srv.dac = r.srv.dac + 8'h01;
					next_r.inc     = r.inc + 5'h01;
				end
				if (!s.fine_n) begin
					next_r.srv.coarse      = 1'b0;
					next_r.srv.settle_in_n = 1'b0;
					next_r.tmr = 32'(CAPTURE_CYC);
					next_r.st  = dss_pkg::ST_CAPTURE;
				end
			end
			// Multi track: ramp on the step enable
			dss_pkg::ST_ACCEL: begin
				if (tick) begin
					if (r.srv.dac != 8'hff) begin
						next_r.srv.dac = r.srv.dac + 8'h01;
					end
					next_r.loaded = 1'b1;
				end
				if (r.loaded && r.srv.dac >= dss_pkg::vel_table(r.ttg)) begin
					next_r.srv.dac = dss_pkg::vel_table(r.ttg);
					next_r.st = dss_pkg::ST_DECEL;
				end
			end
			// Follow the table crossing by crossing
			dss_pkg::ST_DECEL: begin
				next_r.srv.integ_clamp = (r.ttg >= dss_pkg::INTEG_T);
				next_r.srv.t_le8 = (r.ttg <= dss_pkg::LE8_T);
				next_r.srv.t_eq1 = (r.ttg == dss_pkg::ONE_TRACK);
				if (cp) begin
					next_r.srv.dac = dss_pkg::vel_table(ttg_dec);
					next_r.srv.integ_clamp = 1'b1;
				end
				if (r.ttg == dss_pkg::ONE_TRACK && !s.fine_n) begin
					next_r.srv.coarse      = 1'b0;
					next_r.srv.settle_in_n = 1'b0;
					next_r.tmr = 32'(CAPTURE_CYC);
					next_r.st  = dss_pkg::ST_CAPTURE;
				end
			end
			// Track capture delay, then follow
			dss_pkg::ST_CAPTURE: begin
				if (r.tmr == 32'h0) begin
					next_r.srv.track_follow_n = 1'b0;
					next_r.st = dss_pkg::ST_WAIT_OC;
				end
			end
			// Wait for on-cylinder sense
			dss_pkg::ST_WAIT_OC: begin
				if (s.oc_sense) begin
					next_r.tmr   = 32'(SETTLE_CYC);
					next_r.pcnt  = 2'h0;
					next_r.guard = 1'b0;
					next_r.st    = dss_pkg::ST_SETTLE;
				end
			end
			// Sense must hold for the settle time
			dss_pkg::ST_SETTLE: begin
				if (!s.oc_sense) begin
					next_r.tmr = 32'(REGAIN_CYC);
					next_r.st  = dss_pkg::ST_REGAIN;
				end else if (r.tmr == 32'h0) begin
					if (s.demod_n || r.guard) begin
						fail  = 1'b1;
						fcode = dss_pkg::FC_FINAL;
					end else begin
						done = 1'b1;
					end
				end
			end
			// Sense lost: allow it to return
			dss_pkg::ST_REGAIN: begin
				if (s.oc_sense) begin
					next_r.tmr = 32'(SETTLE_CYC);
					next_r.st  = dss_pkg::ST_SETTLE;
				end else if (r.tmr == 32'h0) begin
					fail  = 1'b1;
					fcode = dss_pkg::FC_REGAIN;
				end
			end
			default: begin
				next_r.st = dss_pkg::ST_IDLE;
			end
		endcase
		// Overshoot and guard pulses while settling
		if (r.st == dss_pkg::ST_SETTLE || r.st == dss_pkg::ST_REGAIN) begin
			if (s.guard) begin
				next_r.guard = 1'b1;
			end
			if (cp) begin
				next_r.pcnt = r.pcnt + 2'h1;
				if (r.pcnt == dss_pkg::OVERSHOOT_N - 2'h1) begin
					fail  = 1'b1;
					fcode = dss_pkg::FC_OVER;
				end
			end
		end
		// Seek timeout overrides the phase, except a success in the same cycle
		if (moving && r.tout == 32'h0 && !done) begin
			fail  = 1'b1;
			fcode = dss_pkg::FC_TIMEOUT;
		end
		// Finish
		if (fail) begin
			next_r.err  = 1'b1;
			next_r.send = 1'b1;
			next_r.code = fcode;
		end else if (done) begin
			next_r.srv.flasher = 1'b0;
			next_r.on_cyl  = 1'b1;
			next_r.send    = 1'b1;
			next_r.code    = dss_pkg::FC_NONE;
			next_r.present = r.cyl;
		end
		if (fail || done) begin
			next_r.srv.coarse      = 1'b0;
			next_r.srv.integ_clamp = 1'b1;
			next_r.srv.dac         = 8'h00;
			next_r.st = dss_pkg::ST_IDLE;
		end
		// Bus: read data for the address phase
		ap_ok = hsel_i & htrans_i[1] & hready_i;
		case (haddr_i[7:0])
			dss_pkg::A_CTRL:   rd = {31'h0, r.en};
			dss_pkg::A_STATUS: rd = {15'h0, r.st, r.code, 1'b0, r.send,
			                         r.err, r.on_cyl};
			dss_pkg::A_ADDR:   rd = {6'h0, r.present, 6'h0, r.cyl};
			dss_pkg::A_HEAD:   rd = {27'h0, r.head};
			dss_pkg::A_MUX:    rd = {25'h0, r.midx, r.path};
			default:           rd = 32'h0;
		endcase
		next_r.ap_wr   = ap_ok & hwrite_i;
		next_r.ap_addr = haddr_i[7:0];
		if (ap_ok && !hwrite_i) begin
			next_r.rdata = rd;
		end
		// Bus: writes in the data phase
		if (r.ap_wr) begin
			case (r.ap_addr)
				dss_pkg::A_CTRL: begin
					next_r.en = hwdata_i[dss_pkg::C_EN];
					if (hwdata_i[dss_pkg::C_REWIND]) begin
						next_r.midx = 2'h0;
					end else if (hwdata_i[dss_pkg::C_STEP]) begin
						next_r.midx = r.midx + 2'h1;
					end
				end
				dss_pkg::A_HEAD: next_r.head = hwdata_i[4:0];
				default: begin
				end
			endcase
		end
		// Multiplexer: two cylinder nibbles, then the top two cylinder bits, then head
		case (next_r.midx)
			2'h0:    next_r.path = {1'b0, r.cyl[3:0]};
			2'h1:    next_r.path = {1'b0, r.cyl[7:4]};
			2'h2:    next_r.path = {3'h0, r.cyl[9:8]};
			default: next_r.path = r.head;
		endcase
	end

	// ----------------------------------------------------------------
	// Register the state
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= dss_pkg::ST_IDLE;
			r.en <= 1'b1;
			r.on_cyl <= 1'b1;
			r.ready <= 1'b1;
			r.srv.forward_n <= 1'b1;
			r.srv.settle_in_n <= 1'b1;
			r.srv.integ_clamp <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign servo_o                  = r.srv;
	assign seek_irq_o               = r.irq;
	assign track_reached_flag_o     = r.on_cyl;
	assign positioning_fault_flag_o = r.err;
	assign seek_end_o               = r.send;
	assign fault_code_o             = r.code;
	assign addr_path_o              = r.path;
	assign hrdata_o                 = r.rdata;
	assign hreadyout_o              = r.ready;
	assign hresp_o                  = 1'b0;

endmodule
`default_nettype wire

/* File: sim/dss_seq_props.sv */
/* Checker on the seek sequencer's ports.
 * Assumes one clock domain; bound to dss_seq. */
`timescale 1ns/1ps
`default_nettype none
module dss_seq_props (
	input wire logic                clock_i,
	input wire logic                rst_n_i,
	input wire dss_pkg::dss_servo_t servo_o,
	input wire logic                seek_irq_o,
	input wire logic                track_reached_flag_o,
	input wire logic                positioning_fault_flag_o,
	input wire logic                seek_end_o,
	input wire logic [3:0]          fault_code_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	irq_clear_a: assert property (seek_irq_o |-> !track_reached_flag_o) else $error("flag kept");
	irq_once_a: assert property (seek_irq_o |=> !seek_irq_o) else $error("long irq");
	fail_end_a: assert property (positioning_fault_flag_o |-> seek_end_o && fault_code_o != 4'h0) else $error("fail");
	ok_end_a: assert property ($rose(track_reached_flag_o) |-> seek_end_o && !servo_o.flasher) else $error("ok");
	end_one_a: assert property (seek_end_o |-> track_reached_flag_o != positioning_fault_flag_o) else $error("end");
	coarse_tf_a: assert property (servo_o.coarse |-> servo_o.track_follow_n) else $error("coarse");
	no_move_a: assert property (fault_code_o inside {4'h1, 4'h2} |-> !servo_o.coarse) else $error("moved");
	dac_hold_a: assert property ($changed(servo_o.dac) && servo_o.coarse |=> $stable(servo_o.dac)[*8]) else $error("dac");
endmodule
bind dss_seq dss_seq_props props_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .servo_o(servo_o), .seek_irq_o(seek_irq_o),
	.track_reached_flag_o(track_reached_flag_o), .positioning_fault_flag_o(positioning_fault_flag_o),
	.seek_end_o(seek_end_o), .fault_code_o(fault_code_o));
`default_nettype wire

/* File: sim/dss_host.sv */
/* Host model: sets the bus, then pulses the select tag.
 * Assumes go_i lasts one cycle. */
`timescale 1ns/1ps
`default_nettype none
module dss_host (
	input  wire logic       clock_i,
	input  wire logic       go_i,
	input  wire logic [9:0] cyl_i,
	output logic            tag_o,
	output logic [9:0]      bus_o
);
	// Bus stands steady around the tag, then shows no stale value
	initial begin
		tag_o = 0;
		bus_o = 10'h155;
		forever @(posedge clock_i) if (go_i) begin
			bus_o <= cyl_i;
			repeat (2) @(posedge clock_i);
			tag_o <= 1;
			repeat (4) @(posedge clock_i);
			tag_o <= 0;
			repeat (2) @(posedge clock_i);
			bus_o <= ~cyl_i;
		end
	end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
/* Bench: register access and seeks.
 * Assumes dss_host and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rst_n, go, tag, hsel, hw, rdy, seen, hrs;
	logic [2:0] hsz;
	logic [4:0] pth;
	logic [9:0] dest, bus, d;
	logic [1:0] htr;
	logic [31:0] ha, hwd, hrd, sv, rd, seed, q[$];
	dss_pkg::dss_sense_t sn;
	dss_pkg::dss_servo_t so;
	int error_cnt, checks_done;
	dss_host host (.clock_i(clk), .go_i(go), .cyl_i(dest), .tag_o(tag), .bus_o(bus));
	dss_seq #(.TIMEOUT_CYC(4000), .STEP_CYC(20), .CAPTURE_CYC(50), .SETTLE_CYC(100), .REGAIN_CYC(200)) dut (
		.clock_i(clk), .rst_n_i(rst_n), .cyl_tag_i(tag), .cyl_bus_i(bus), .sense_i(sn), .servo_o(so),
		.seek_irq_o(), .track_reached_flag_o(), .positioning_fault_flag_o(), .seek_end_o(), .fault_code_o(),
		.addr_path_o(pth), .hsel_i(hsel), .haddr_i(ha), .htrans_i(htr), .hwrite_i(hw), .hsize_i(hsz),
		.hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy), .hresp_o(hrs));
	initial begin clk = 0; forever #2.5 clk = ~clk; end
	function automatic logic [31:0] xs(input logic [31:0] s); s ^= s << 13; s ^= s >> 17; return s ^ (s << 5); endfunction
	task chk(input logic [31:0] v, e);
		checks_done++;
		if (v !== e) begin error_cnt++; $display("wrong value at %0t: %h expected %h", $time, v, e); end
	endtask
	// Note a result; the monitor compares it at the next edge
	task note(input logic [31:0] v, e); q.push_back(e); sv <= v; seen <= 1; repeat (2) @(posedge clk); endtask
	always @(posedge clk) if (seen) begin chk(sv, q.pop_front()); seen <= 0; end
	// One single AHB-Lite transfer
	task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk); hsel <= 1; ha <= {24'h0, a}; htr <= 2'h2; hw <= w; hsz <= 3'h2;
		do @(posedge clk); while (rdy !== 1);
		hsel <= 0; htr <= 2'h0; hwd <= wd;
		do @(posedge clk); while (rdy !== 1);
		rd = hrd;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e); ahb(a, 0, 0); note(rd, e); endtask
	task wend; do ahb(8'h04, 0, 0); while (rd[2] !== 1); endtask
	task seek(input logic [9:0] x); @(posedge clk); dest <= x; go <= 1; @(posedge clk); go <= 0; repeat (12) @(posedge clk); endtask
	// Fine loop entry and settle; g[0] shows a guard pulse, g[1] three crossings
	task land(input logic [31:0] a, e, input logic [1:0] g);
		sn.fine_n <= 0; repeat (100) @(posedge clk); sn.oc_sense <= 1; sn.guard <= g[0];
		if (g[1]) repeat (3) begin repeat (10) @(posedge clk); sn.cyl_pulse <= 1; repeat (4) @(posedge clk); sn.cyl_pulse <= 0; end
		wend;
		note(rd, e);
		rdc(8'h08, a);
		sn.fine_n <= 1; sn.oc_sense <= 0; sn.guard <= 0;
	endtask
	task final_report;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		{rst_n, go, dest, hsel, ha, htr, hw, hwd, seen, hsz} = 0; sn = 7'h18; seed = xs(32'h51ed0b7e);
		repeat (2) @(posedge clk); rst_n <= 1; repeat (4) @(posedge clk);
		rdc(8'h00, 32'h1); ahb(8'h0c, 1, seed); rdc(8'h0c, {27'h0, seed[4:0]}); rdc(8'h20, 32'h0);
		seek(10'h000); rdc(8'h04, 32'h101);
		seek(10'h2c7); wend; note(rd, 32'h116);
		rdc(8'h08, 32'h2c7);
		ahb(8'h00, 1, 32'h3); rdc(8'h10, 32'h2c); note(pth, 32'hc); note(hrs, 32'h0); ahb(8'h00, 1, 32'h5);
		$display("test 1 done");
		seek(10'h001); note({so.forward_n, so.track_follow_n, so.coarse}, 3);
		repeat (400) @(posedge clk); note(so.dac, 32'h10);
		land(32'h00010001, 32'h105, 2'h0);
		d = 10'h004 + seed[10:8]; seek(d); repeat (1100) @(posedge clk);
		repeat (d - 10'h002) begin sn.cyl_pulse <= 1; repeat (4) @(posedge clk); sn.cyl_pulse <= 0; repeat (10) @(posedge clk); end
		land({6'h0, d, 6'h0, d}, 32'h105, 2'h0);
		$display("test 2 done");
		sn.speed_ok <= 0; seek(10'h000); wend; note(rd, 32'h126);
		sn.speed_ok <= 1; sn.fault <= 1; seek(10'h001); wend; note(rd, 32'h126);
		sn.fault <= 0; sn.demod_n <= 1; seek(10'h000); wend; note(rd, 32'h126);
		sn.demod_n <= 0; seek(10'h001); wend; note(rd, 32'h136);
		$display("test 3 done");
		seek(d + 10'h001); land({6'h0, d, 6'h0, d + 10'h001}, 32'h166, 2'h1);
		seek(d - 10'h001); land({6'h0, d, 6'h0, d - 10'h001}, 32'h156, 2'h2);
		$display("test 4 done");
		final_report;
	end
	initial begin repeat (20000) @(posedge clk); error_cnt++; final_report; end
endmodule
`default_nettype wire
